// *** verilog/port_b_bus_matching_defs.vh ***
`ifndef PORT_B_BUS_MATCHING_DEFS_VH
`define PORT_B_BUS_MATCHING_DEFS_VH

// ==========================================================================
// Data widths and lanes
`define LW_W            36
`define HALF_W          18
`define BYTE_W          9
`define LANE_W          2
`define LANE_FIRST      2'h0
`define LANE_INC        2'h1
`define LANE_LAST_LONG  2'h0
`define LANE_LAST_WORD  2'h1
`define LANE_LAST_BYTE  2'h3
`define BYTE_TOP        2'h3

// ==========================================================================
// Queue storage
`define QUEUE_AW        4
`define QUEUE_DEPTH     16
`define QUEUE_PTR_INC   4'h1
`define CNT_W           5
`define CNT_ZERO        5'h00

// ==========================================================================
// Register port
`define REG_AW          2
`define REG_DW          8
`define REG_CTRL        2'h0
`define REG_STATUS      2'h1
`define REG_LEVELS      2'h2
`define CTRL_PRS_AB     0
`define CTRL_PRS_BA     1
`define STAT_BIG        0
`define STAT_FALL_THROUGH_MODE       1
`define STAT_RD_LANE    2
`define STAT_WR_LANE    4
`define STAT_MR_ACTIVE  6
`define REG_ZERO        8'h00

`endif

// *** verilog/event_sync.v ***
`timescale 1ns/10ps
`include "port_b_bus_matching_defs.vh"

// ==========================================================================
// Toggle synchroniser from one port-clock tick rate to the other
module event_sync (
	input  wire clk,
	input  wire rst_n,
	input  wire clear,
	input  wire src_pulse,
	input  wire dst_tick,
	output wire dst_event
);

	reg toggle_reg;
	reg s1_reg;
	reg s2_reg;
	reg s3_reg;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			toggle_reg <= 1'b0;
			s1_reg     <= 1'b0;
			s2_reg     <= 1'b0;
			s3_reg     <= 1'b0;
		end else if (clear) begin
			toggle_reg <= 1'b0;
			s1_reg     <= 1'b0;
			s2_reg     <= 1'b0;
			s3_reg     <= 1'b0;
		end else begin
			if (src_pulse)
				toggle_reg <= ~toggle_reg;
			// Each stage feeds the next, and only on a destination tick
			if (dst_tick) begin
				s1_reg <= toggle_reg;
				s2_reg <= s1_reg;
				s3_reg <= s2_reg;
			end
		end
	end

	assign dst_event = dst_tick & (s2_reg ^ s3_reg);

endmodule // event_sync

// *** verilog/lw_queue.v ***
`timescale 1ns/10ps
`include "port_b_bus_matching_defs.vh"

// ==========================================================================
// Long-word queue storage; occupancy is tracked by the caller
module lw_queue (
	input  wire              clk,
	input  wire              rst_n,
	input  wire              clear,
	input  wire              wr_en,
	input  wire [`LW_W-1:0]  wr_data,
	input  wire              rd_en,
	output wire [`LW_W-1:0]  rd_data
);

	reg [`LW_W-1:0]     mem [0:`QUEUE_DEPTH-1];
	reg [`QUEUE_AW-1:0] wr_ptr_reg;
	reg [`QUEUE_AW-1:0] rd_ptr_reg;

	always @(posedge clk) begin
		if (wr_en)
			mem[wr_ptr_reg] <= wr_data;
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_reg <= {`QUEUE_AW{1'b0}};
			rd_ptr_reg <= {`QUEUE_AW{1'b0}};
		end else if (clear) begin
			wr_ptr_reg <= {`QUEUE_AW{1'b0}};
			rd_ptr_reg <= {`QUEUE_AW{1'b0}};
		end else begin
			if (wr_en)
				wr_ptr_reg <= wr_ptr_reg + `QUEUE_PTR_INC;
			if (rd_en)
				rd_ptr_reg <= rd_ptr_reg + `QUEUE_PTR_INC;
		end
	end

	assign rd_data = mem[rd_ptr_reg];

endmodule // lw_queue

// *** verilog/port_b_bus_matching_flags.v ***
// Summary of operation
// R01 - Outside logic keeps width selects static; byte order taken only at master reset.
// R02 - Long-word mode passes 36-bit words lane for lane, ignoring size and order.
// R03 - Word mode big-endian: first B write is upper half, second lower half.
// R04 - Word mode little-endian: first B write is lower half, second upper half.
// R05 - Byte mode: four writes fill MSB downward (big) or LSB upward (little).
// R06 - Word reads give upper then lower half (big) or lower then upper (little).
// R07 - Byte reads give four bytes on lines 8-0, MSB or LSB first.
// R08 - Word reads leave B lines 35-18 undefined; here they read zero.
// R09 - Byte reads leave upper three byte lanes undefined; here they read zero.
// R10 - Fall-through: A write to empty queue raises B ready and loads on third B edge.
// R11 - Too little clock skew may add one B cycle to that rise and load.
// R12 - B ready drops only on the last lane read that empties the queue.
// R13 - Standard mode: A write to empty queue raises B not-empty after synchronisation.
// R14 - Standard mode: B empty flag asserts on the last lane read emptying queue.
// R15 - Fall-through: completed B long word raises A ready and loads on third A edge.
// R16 - A flag timing starts at the B edge writing the final lane.
// R17 - Too little clock skew may add one A cycle to that rise and load.
// R18 - Full long word enters queue on final lane write; parts held until then.
// R19 - Byte order and mode latched at the release of master reset.
// R20 - Word and byte writes ignore B lines outside the selected lanes.
// R21 - Lane counters per direction reset on master or partial reset, wrap per word.
// R22 - Write events cross between port clocks through a two-stage synchroniser.
`timescale 1ns/10ps
`include "port_b_bus_matching_defs.vh"

module port_b_bus_matching_flags (
	input  wire               clk,
	input  wire               rst_n,
	input  wire               master_reset_one_n,
	input  wire               master_reset_two_n,
	input  wire               width_match_select,
	input  wire               bus_width_select,
	input  wire               byte_order_select,
	input  wire               fall_through_mode,
	input  wire               port_a_clock,
	input  wire               port_a_chip_select_n,
	input  wire               port_a_direction,
	input  wire               port_a_transfer_gate,
	input  wire               port_a_mail_select,
	input  wire [`LW_W-1:0]   port_a_data_in,
	output reg  [`LW_W-1:0]   port_a_data_out,
	output reg                port_a_data_oe,
	input  wire               port_b_clock,
	input  wire               port_b_chip_select_n,
	input  wire               port_b_direction,
	input  wire               port_b_transfer_gate,
	input  wire               port_b_mail_select,
	input  wire [`LW_W-1:0]   port_b_data_in,
	output reg  [`LW_W-1:0]   port_b_data_out,
	output reg                port_b_data_oe,
	output reg                a_side_output_ready,
	output reg                a_side_empty_flag_n,
	output reg                b_side_output_ready,
	output reg                b_side_empty_flag_n,
	input  wire [`REG_AW-1:0] reg_addr,
	input  wire [`REG_DW-1:0] reg_wdata,
	input  wire               reg_wr,
	input  wire               reg_rd,
	output reg  [`REG_DW-1:0] reg_rdata
);

	// ======================================================================
	// Lane helpers
	function [`LANE_W-1:0] last_lane;
		input match;
		input bytes;
		begin
			if (!match)
				last_lane = `LANE_LAST_LONG;
			else if (!bytes)
				last_lane = `LANE_LAST_WORD;
			else
				last_lane = `LANE_LAST_BYTE;
		end
	endfunction

	function [`LW_W-1:0] lane_pick;
		input [`LW_W-1:0]   w;
		input [`LANE_W-1:0] lane;
		input               match;
		input               bytes;
		input               big;
		reg   [`LANE_W-1:0] k;
		begin
			k = big ? (`BYTE_TOP - lane) : lane;
			lane_pick = {`LW_W{1'b0}};
			if (!match)
				lane_pick = w; // R02
			else if (!bytes) begin
				if ((lane == `LANE_FIRST) == big)
					lane_pick[`HALF_W-1:0] = w[`LW_W-1:`HALF_W]; // R06 R08
				else
					lane_pick[`HALF_W-1:0] = w[`HALF_W-1:0]; // R06 R08
			end else
				lane_pick[`BYTE_W-1:0] = w[k*`BYTE_W +: `BYTE_W]; // R07 R09
		end
	endfunction

	function [`LW_W-1:0] lane_put;
		input [`LW_W-1:0]   w;
		input [`LW_W-1:0]   din;
		input [`LANE_W-1:0] lane;
		input               match;
		input               bytes;
		input               big;
		reg   [`LANE_W-1:0] k;
		begin
			k = big ? (`BYTE_TOP - lane) : lane;
			lane_put = w;
			if (!match)
				lane_put = din; // R02
			else if (!bytes) begin
				if ((lane == `LANE_FIRST) == big)
					lane_put[`LW_W-1:`HALF_W] = din[`HALF_W-1:0]; // R03 R04 R20
				else
					lane_put[`HALF_W-1:0] = din[`HALF_W-1:0]; // R03 R04 R20
			end else
				lane_put[k*`BYTE_W +: `BYTE_W] = din[`BYTE_W-1:0]; // R05 R20
		end
	endfunction

	// ======================================================================
	// Port clock ticks and configuration
	reg                a_clk_d_reg;
	reg                b_clk_d_reg;
	reg                mr_hold_reg;
	reg                cfg_big_reg;
	reg                cfg_fall_through_mode_reg;
	reg                prs_ab_reg;
	reg                prs_ba_reg;
	wire               a_tick;
	wire               b_tick;
	wire               mr_low;
	wire               clear_ab;
	wire               clear_ba;
	wire [`LANE_W-1:0] lane_last;

	// Port clocks are sampled levels; each rising edge is a one-cycle tick
	assign a_tick    = port_a_clock & ~a_clk_d_reg;
	assign b_tick    = port_b_clock & ~b_clk_d_reg;
	assign mr_low    = ~master_reset_one_n | ~master_reset_two_n;
	assign clear_ab  = mr_low | prs_ab_reg; // R21
	assign clear_ba  = mr_low | prs_ba_reg; // R21
	assign lane_last = last_lane(width_match_select, bus_width_select);

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			a_clk_d_reg  <= 1'b0;
			b_clk_d_reg  <= 1'b0;
			mr_hold_reg  <= 1'b0;
			cfg_big_reg  <= 1'b1;
			cfg_fall_through_mode_reg <= 1'b0;
		end else begin
			a_clk_d_reg <= port_a_clock;
			b_clk_d_reg <= port_b_clock;
			mr_hold_reg <= mr_low;
			// Captured on the release of master reset, held until the next
			if (mr_hold_reg && !mr_low) begin
				cfg_big_reg  <= byte_order_select; // R01 R19
				cfg_fall_through_mode_reg <= fall_through_mode; // R19
			end
		end
	end

	// ======================================================================
	// Transfer decode
	wire a_wr;
	wire a_rd_req;
	wire b_wr;
	wire b_rd_req;

	assign a_wr     = a_tick & ~port_a_chip_select_n & port_a_direction
	                & port_a_transfer_gate & ~port_a_mail_select & ~clear_ab;
	assign a_rd_req = a_tick & ~port_a_chip_select_n & ~port_a_direction
	                & port_a_transfer_gate & ~port_a_mail_select & ~clear_ba;
	assign b_wr     = b_tick & ~port_b_chip_select_n & ~port_b_direction
	                & port_b_transfer_gate & ~port_b_mail_select & ~clear_ba;
	assign b_rd_req = b_tick & ~port_b_chip_select_n & port_b_direction
	                & port_b_transfer_gate & ~port_b_mail_select & ~clear_ab;

	// ======================================================================
	// Port B write assembly into the B-to-A queue
	reg  [`LW_W-1:0]   b_asm_reg;
	reg  [`LANE_W-1:0] b_lane_wr_reg;
	wire [`LW_W-1:0]   b_asm_word;
	wire               b_push;

	assign b_asm_word = lane_put(b_asm_reg, port_b_data_in, b_lane_wr_reg,
	                             width_match_select, bus_width_select, cfg_big_reg);
	assign b_push     = b_wr & (b_lane_wr_reg == lane_last); // R18

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			b_asm_reg     <= {`LW_W{1'b0}};
			b_lane_wr_reg <= `LANE_FIRST;
		end else if (clear_ba) begin
			b_lane_wr_reg <= `LANE_FIRST; // R21
		end else if (b_wr) begin
			b_asm_reg <= b_asm_word; // R18
			if (b_lane_wr_reg == lane_last)
				b_lane_wr_reg <= `LANE_FIRST; // R21
			else
				b_lane_wr_reg <= b_lane_wr_reg + `LANE_INC;
		end
	end

	// ======================================================================
	// Queues and event crossings
	wire [`LW_W-1:0] ab_mem_word;
	wire [`LW_W-1:0] ba_mem_word;
	wire             ab_evt;
	wire             ba_evt;
	reg              ab_pop;
	reg              ba_pop;

	lw_queue u_a_to_b_queue (
		.clk     (clk),
		.rst_n   (rst_n),
		.clear   (clear_ab),
		.wr_en   (a_wr),
		.wr_data (port_a_data_in),
		.rd_en   (ab_pop),
		.rd_data (ab_mem_word)
	);

	lw_queue u_b_to_a_queue (
		.clk     (clk),
		.rst_n   (rst_n),
		.clear   (clear_ba),
		.wr_en   (b_push),
		.wr_data (b_asm_word),
		.rd_en   (ba_pop),
		.rd_data (ba_mem_word)
	);

	// A coincident source tick misses stage one: the extra cycle of skew
	event_sync u_ab_sync (
		.clk       (clk),
		.rst_n     (rst_n),
		.clear     (clear_ab),
		.src_pulse (a_wr),
		.dst_tick  (b_tick),
		.dst_event (ab_evt)
	); // R10 R11 R22

	event_sync u_ba_sync (
		.clk       (clk),
		.rst_n     (rst_n),
		.clear     (clear_ba),
		.src_pulse (b_push),
		.dst_tick  (a_tick),
		.dst_event (ba_evt)
	); // R15 R16 R17 R22

	// ======================================================================
	// Port B read side, splitting long words
	reg  [`CNT_W-1:0]  ab_avail_reg;
	reg  [`CNT_W-1:0]  ab_avail_next;
	reg  [`LW_W-1:0]   b_hold_reg;
	reg  [`LW_W-1:0]   b_hold_next;
	reg  [`LW_W-1:0]   b_out_reg;
	reg  [`LW_W-1:0]   b_out_next;
	reg  [`LANE_W-1:0] b_lane_rd_reg;
	reg  [`LANE_W-1:0] b_lane_rd_next;
	reg                b_ready_reg;
	reg                b_ready_next;
	wire               b_has;

	assign b_has = (ab_avail_reg != `CNT_ZERO) | ab_evt;

	always @* begin
		ab_pop         = 1'b0;
		b_hold_next    = b_hold_reg;
		b_out_next     = b_out_reg;
		b_lane_rd_next = b_lane_rd_reg;
		b_ready_next   = b_ready_reg;
		if (b_tick && cfg_fall_through_mode_reg) begin
			if (b_ready_reg && b_rd_req && b_lane_rd_reg != lane_last) begin
				b_lane_rd_next = b_lane_rd_reg + `LANE_INC;
				b_out_next     = lane_pick(b_hold_reg, b_lane_rd_next, width_match_select,
				                           bus_width_select, cfg_big_reg);
			end else if (!b_ready_reg || b_rd_req) begin
				b_lane_rd_next = `LANE_FIRST;
				if (b_has) begin
					ab_pop       = 1'b1; // R10
					b_hold_next  = ab_mem_word;
					b_out_next   = lane_pick(ab_mem_word, `LANE_FIRST, width_match_select,
					                         bus_width_select, cfg_big_reg);
					b_ready_next = 1'b1; // R10
				end else
					b_ready_next = 1'b0; // R12
			end
		end else if (b_tick && b_rd_req && b_ready_reg) begin
			if (b_lane_rd_reg == `LANE_FIRST) begin
				ab_pop      = 1'b1;
				b_hold_next = ab_mem_word;
				b_out_next  = lane_pick(ab_mem_word, `LANE_FIRST, width_match_select,
				                        bus_width_select, cfg_big_reg);
			end else
				b_out_next = lane_pick(b_hold_reg, b_lane_rd_reg, width_match_select,
				                       bus_width_select, cfg_big_reg);
			if (b_lane_rd_reg == lane_last)
				b_lane_rd_next = `LANE_FIRST; // R21
			else
				b_lane_rd_next = b_lane_rd_reg + `LANE_INC;
		end
		ab_avail_next = ab_avail_reg + {{(`CNT_W-1){1'b0}}, ab_evt}
		              - {{(`CNT_W-1){1'b0}}, ab_pop};
		// Standard mode: pending lanes still count as data
		if (b_tick && !cfg_fall_through_mode_reg)
			b_ready_next = (ab_avail_next != `CNT_ZERO)
			             | (b_lane_rd_next != `LANE_FIRST); // R13 R14
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ab_avail_reg        <= `CNT_ZERO;
			b_hold_reg          <= {`LW_W{1'b0}};
			b_out_reg           <= {`LW_W{1'b0}};
			b_lane_rd_reg       <= `LANE_FIRST;
			b_ready_reg         <= 1'b0;
			b_side_output_ready <= 1'b0;
			b_side_empty_flag_n <= 1'b0;
		end else if (clear_ab) begin
			ab_avail_reg        <= `CNT_ZERO;
			b_lane_rd_reg       <= `LANE_FIRST; // R21
			b_ready_reg         <= 1'b0;
			b_side_output_ready <= 1'b0;
			b_side_empty_flag_n <= 1'b0;
		end else begin
			ab_avail_reg        <= ab_avail_next;
			b_hold_reg          <= b_hold_next;
			b_out_reg           <= b_out_next;
			b_lane_rd_reg       <= b_lane_rd_next;
			b_ready_reg         <= b_ready_next;
			b_side_output_ready <= b_ready_next & cfg_fall_through_mode_reg; // R10 R12
			b_side_empty_flag_n <= b_ready_next & ~cfg_fall_through_mode_reg; // R13 R14
		end
	end

	// ======================================================================
	// Port A read side, whole long words
	reg  [`CNT_W-1:0] ba_avail_reg;
	reg  [`CNT_W-1:0] ba_avail_next;
	reg  [`LW_W-1:0]  a_out_reg;
	reg  [`LW_W-1:0]  a_out_next;
	reg               a_ready_reg;
	reg               a_ready_next;
	wire              a_has;

	assign a_has = (ba_avail_reg != `CNT_ZERO) | ba_evt;

	always @* begin
		ba_pop       = 1'b0;
		a_out_next   = a_out_reg;
		a_ready_next = a_ready_reg;
		if (a_tick && cfg_fall_through_mode_reg) begin
			if (!a_ready_reg || a_rd_req) begin
				if (a_has) begin
					ba_pop       = 1'b1; // R15
					a_out_next   = ba_mem_word;
					a_ready_next = 1'b1; // R15
				end else
					a_ready_next = 1'b0;
			end
		end else if (a_tick && a_rd_req && a_ready_reg) begin
			ba_pop     = 1'b1;
			a_out_next = ba_mem_word;
		end
		ba_avail_next = ba_avail_reg + {{(`CNT_W-1){1'b0}}, ba_evt}
		              - {{(`CNT_W-1){1'b0}}, ba_pop};
		if (a_tick && !cfg_fall_through_mode_reg)
			a_ready_next = (ba_avail_next != `CNT_ZERO); // R16
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ba_avail_reg        <= `CNT_ZERO;
			a_out_reg           <= {`LW_W{1'b0}};
			a_ready_reg         <= 1'b0;
			a_side_output_ready <= 1'b0;
			a_side_empty_flag_n <= 1'b0;
		end else if (clear_ba) begin
			ba_avail_reg        <= `CNT_ZERO;
			a_ready_reg         <= 1'b0;
			a_side_output_ready <= 1'b0;
			a_side_empty_flag_n <= 1'b0;
		end else begin
			ba_avail_reg        <= ba_avail_next;
			a_out_reg           <= a_out_next;
			a_ready_reg         <= a_ready_next;
			a_side_output_ready <= a_ready_next & cfg_fall_through_mode_reg; // R15
			a_side_empty_flag_n <= a_ready_next & ~cfg_fall_through_mode_reg;
		end
	end

	// ======================================================================
	// Data outputs; enables lag the selects by one clock
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			port_a_data_out <= {`LW_W{1'b0}};
			port_b_data_out <= {`LW_W{1'b0}};
			port_a_data_oe  <= 1'b0;
			port_b_data_oe  <= 1'b0;
		end else begin
			port_a_data_out <= a_out_next;
			port_b_data_out <= b_out_next;
			port_a_data_oe  <= ~port_a_chip_select_n & ~port_a_direction;
			port_b_data_oe  <= ~port_b_chip_select_n & port_b_direction;
		end
	end

	// ======================================================================
	// Register port: partial reset strobes and status
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prs_ab_reg <= 1'b0;
			prs_ba_reg <= 1'b0;
			reg_rdata  <= `REG_ZERO;
		end else begin
			prs_ab_reg <= reg_wr & (reg_addr == `REG_CTRL) & reg_wdata[`CTRL_PRS_AB];
			prs_ba_reg <= reg_wr & (reg_addr == `REG_CTRL) & reg_wdata[`CTRL_PRS_BA];
			reg_rdata  <= `REG_ZERO;
			if (reg_rd) begin
				case (reg_addr)
				`REG_STATUS: begin
					reg_rdata[`STAT_BIG]                   <= cfg_big_reg;
					reg_rdata[`STAT_FALL_THROUGH_MODE]                  <= cfg_fall_through_mode_reg;
					reg_rdata[`STAT_RD_LANE +: `LANE_W]    <= b_lane_rd_reg;
					reg_rdata[`STAT_WR_LANE +: `LANE_W]    <= b_lane_wr_reg;
					reg_rdata[`STAT_MR_ACTIVE]             <= mr_hold_reg;
				end
				`REG_LEVELS: begin
					reg_rdata <= {ab_avail_reg[`CNT_W-2:0], ba_avail_reg[`CNT_W-2:0]};
				end
				default: begin
					reg_rdata <= `REG_ZERO;
				end
				endcase
			end
		end
	end

endmodule // port_b_bus_matching_flags

// *** tb/port_clock_source.sv ***
`timescale 1ns/10ps
// ==========================================
// Far-side port clocks, free running
module port_clock_source (
	input  wire  clk,
	input  wire  rst_n,
	output logic port_a_clock,
	output logic port_b_clock
);
	logic [2:0] cnt_b;

	// Periods of 2 and 5 clk: B ticks fall both on and between A ticks
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			port_a_clock <= 1'h0;
			port_b_clock <= 1'h0;
			cnt_b <= 3'h0;
		end else begin
			port_a_clock <= ~port_a_clock;
			cnt_b <= (cnt_b == 3'h4) ? 3'h0 : cnt_b + 3'h1;
			port_b_clock <= (cnt_b < 3'h2);
		end
	end
endmodule // port_clock_source

// *** tb/bmf_sva.sv ***
`timescale 1ns/10ps
// ==========================================
// Flag edges tied to port clock ticks
module bmf_sva (
	input wire clk,
	input wire rst_n,
	input wire master_reset_one_n,
	input wire port_a_clock,
	input wire port_b_clock,
	input wire a_side_output_ready,
	input wire a_side_empty_flag_n,
	input wire b_side_output_ready,
	input wire b_side_empty_flag_n
);
	logic pa_q;
	logic pb_q;
	wire  atk = port_a_clock & ~pa_q;
	wire  btk = port_b_clock & ~pb_q;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pa_q <= 1'h0;
			pb_q <= 1'h0;
		end else begin
			pa_q <= port_a_clock;
			pb_q <= port_b_clock;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	ar_tick_a: assert property ($rose(a_side_output_ready) |-> $past(atk))
		else $error("a ready rose off a port A tick");
	br_tick_a: assert property ($rose(b_side_output_ready) |-> $past(btk))
		else $error("b ready rose off a port B tick");
	ae_tick_a: assert property ($rose(a_side_empty_flag_n) |-> $past(atk))
		else $error("a empty flag rose off a port A tick");
	be_tick_a: assert property ($rose(b_side_empty_flag_n) |-> $past(btk))
		else $error("b empty flag rose off a port B tick");
	a_mode_a: assert property (!(a_side_output_ready && a_side_empty_flag_n))
		else $error("a ready and a empty flag both high");
	b_mode_a: assert property (!(b_side_output_ready && b_side_empty_flag_n))
		else $error("b ready and b empty flag both high");
	ar_fall_a: assert property ($fell(a_side_output_ready) |-> $past(atk)
		|| !master_reset_one_n || !$past(master_reset_one_n, 2))
		else $error("a ready fell off a port A tick");
	br_fall_a: assert property ($fell(b_side_output_ready) |-> $past(btk)
		|| !master_reset_one_n || !$past(master_reset_one_n, 2))
		else $error("b ready fell off a port B tick");
endmodule // bmf_sva

bind port_b_bus_matching_flags bmf_sva sva_u (.*);

// *** tb/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
	logic clk, rst_n, master_reset_one_n, master_reset_two_n, port_a_clock, port_b_clock;
	logic width_match_select, bus_width_select, byte_order_select, fall_through_mode;
	logic port_a_chip_select_n, port_a_direction, port_a_transfer_gate, port_a_mail_select;
	logic port_b_chip_select_n, port_b_direction, port_b_transfer_gate, port_b_mail_select;
	logic port_a_data_oe, port_b_data_oe, reg_wr, reg_rd, pa_q, pb_q;
	logic a_side_output_ready, a_side_empty_flag_n, b_side_output_ready, b_side_empty_flag_n;
	logic [35:0] port_a_data_in, port_a_data_out, port_b_data_in, port_b_data_out, w, d;
	logic [1:0]  reg_addr;
	logic [7:0]  reg_wdata, reg_rdata, rv;
	logic [15:0] sd;
	int miscompares, checks, i, k, n, np, lw, big;
	logic [35:0] mq[$];

	port_b_bus_matching_flags dut_u (.*);
	port_clock_source pcs_u (.*);

	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end

	always @(posedge clk) begin
		pa_q <= port_a_clock;
		pb_q <= port_b_clock;
	end

	function logic [35:0] r36();
		logic [47:0] t;
		for (int j = 0; j < 3; j++) begin
			sd = {sd[14:0], sd[15] ^ sd[13] ^ sd[12] ^ sd[10]};
			t = {t[31:0], sd};
		end
		return t[35:0];
	endfunction

	function logic [35:0] mk();
		return (36'h1 << lw) - 36'h1;
	endfunction

	// Model of lane order: k-th transfer of a long word
	function logic [35:0] ln(input logic [35:0] v, input int k);
		int j;
		j = big ? k : np - 1 - k;
		return (v >> ((np - 1 - j) * lw)) & mk();
	endfunction

	function logic fl(input int p);
		if (p)
			return fall_through_mode ? b_side_output_ready : b_side_empty_flag_n;
		return fall_through_mode ? a_side_output_ready : a_side_empty_flag_n;
	endfunction

	task wt(input int p);
		do @(posedge clk);
		while (!(p ? (port_b_clock && !pb_q) : (port_a_clock && !pa_q)));
	endtask

	// A request is held until the tick that takes it
	task ar(input logic g, dv, input logic [35:0] v);
		wt(0);
		port_a_transfer_gate <= g;
		port_a_direction <= dv;
		port_a_data_in <= v;
	endtask

	task br(input logic g, dv, input logic [35:0] v);
		wt(1);
		port_b_transfer_gate <= g;
		port_b_direction <= dv;
		port_b_data_in <= v;
	endtask

	task rr(input logic [1:0] a);
		@(posedge clk);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'h0;
		#1 rv = reg_rdata;
	endtask

	task rw(input logic [1:0] a, input logic [7:0] v);
		@(posedge clk);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 1'h0;
	endtask

	task cnt(input int p);
		n = 0;
		while (!fl(p) && n < 8) begin
			wt(p);
			#1 n++;
		end
	endtask

	task chk(input logic [35:0] s, e, input string nm);
		checks++;
		if (s !== e) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask

	task give_verdict;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		#100000;
		miscompares++;
		give_verdict;
	end

	initial begin
		{rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, port_a_data_in, port_b_data_in} = '0;
		{port_a_chip_select_n, port_b_chip_select_n, port_a_mail_select} = '0;
		{port_b_mail_select, port_a_transfer_gate, port_b_transfer_gate} = '0;
		{port_a_direction, port_b_direction} = '0;
		{width_match_select, bus_width_select, byte_order_select, fall_through_mode} = '0;
		{master_reset_one_n, master_reset_two_n} = 2'h3;
		sd = 16'hF5CF;
		repeat (8) @(posedge clk);
		rst_n <= 1'h1;
		for (i = 0; i < 10; i++) begin
			np = (i % 5 == 0) ? 1 : (i % 5 > 2) ? 4 : 2;
			lw = 36 / np;
			big = i % 2;
			@(posedge clk);
			{master_reset_one_n, master_reset_two_n} <= 2'h0;
			width_match_select <= (i % 5 != 0);
			bus_width_select <= (i % 5 > 2);
			byte_order_select <= big;
			fall_through_mode <= i / 5;
			repeat (3) @(posedge clk);
			{master_reset_one_n, master_reset_two_n} <= 2'h3;
			repeat (3) @(posedge clk);
			rr(2'h1);
			chk(rv, (i / 5) * 2 + big, "status");
			rr(2'h3);
			chk(rv, 0, "unmapped");
			// Partial long word, then flushed away
			if (np > 1) begin
				br(1, 0, r36());
				br(0, 0, 0);
				rw(2'h0, 8'h02);
			end
			w = r36();
			mq.push_back(w);
			for (k = 0; k < np; k++) begin
				d = ln(w, k);
				if (np > 1)
					d = d | (r36() << lw);
				br(1, 0, d);
			end
			br(0, 0, 0);
			cnt(0);
			chk(n >= 3 && n <= 4, 1, "a flag ticks");
			chk(port_b_data_oe, 0, "b oe idle");
			if (i < 5) begin
				rr(2'h2);
				chk(rv[3:0], 1, "levels");
			end else
				chk(port_a_data_out, mq[0], "a fall through");
			ar(1, 0, 0);
			ar(0, 0, 0);
			#1;
			chk(port_a_data_out, mq.pop_front(), "a data");
			chk(port_a_data_oe, 1, "a oe");
			chk(fl(0), 0, "a flag drop");
			w = r36();
			ar(1, 1, w);
			ar(0, 0, 0);
			cnt(1);
			chk(n >= 3 && n <= 4, 1, "b flag ticks");
			for (k = 0; k < np; k++) begin
				if (i >= 5)
					chk(port_b_data_out & mk(), ln(w, k), "b fall through");
				chk(fl(1), 1, "b flag held");
				br(1, 1, 0);
				br(0, 1, 0);
				#1;
				if (i < 5)
					chk(port_b_data_out & mk(), ln(w, k), "b data");
				chk(port_b_data_oe, 1, "b oe");
			end
			chk(fl(1), 0, "b flag drop");
			$display("test %0d done", i);
		end
		give_verdict;
	end
endmodule // tb_top
